// file: logic/elc_pkg.sv
// package for the external link control block
// offsets are register indices on the plain register port
package elc_pkg;
    localparam int NLINK = 8;
    localparam int GAP_W = 11;
    localparam int EP_W = 5;
    localparam int AW = 8;
    // register indices
    localparam logic [7:0] CTL_BASE = 8'h80;
    localparam logic [7:0] FWD_BASE = 8'hA0;
    localparam logic [7:0] IRQ_STAT = 8'hC0;
    localparam logic [7:0] IRQ_MASK = 8'hC1;
    // link control field positions
    localparam int B_EN = 31;
    localparam int B_WIDE = 30;
    localparam int B_RXERR = 27;
    localparam int B_RXCR = 26;
    localparam int B_TXCR = 25;
    localparam int B_GREET = 24;
    localparam int B_RXRST = 23;
    localparam int SYM_LSB = 11;
    localparam int TOK_LSB = 0;
    // fixed forward field positions
    localparam int F_EN = 31;
    localparam int F_PROC = 8;
    localparam int F_EP_LSB = 0;
    // interrupt status layout: errors low, credit gained high
    localparam int I_ERR_LSB = 0;
    localparam int I_CR_LSB = 8;
    // forward register n serves link n xor this (C,D,A,B,G,H,E,F)
    localparam logic [2:0] FWD_SWAP = 3'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic en;
        logic wide;
        logic [GAP_W-1:0] sym_gap;
        logic [GAP_W-1:0] tok_gap;
    } elc_ctl_s;

    typedef struct packed {
        logic en;
        logic proc;
        logic [EP_W-1:0] endpoint;
    } elc_fwd_s;
endpackage

// file: logic/elc_link_cfg.sv
// link control, status, pacing and fixed forwarding for 8 links
// assumes the link datapath reports events as one-cycle pulses
// and all inputs are synchronous to i_clk
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// symbol pacing for one link transmitter
module elc_pace
    import elc_pkg::*;
#(
    parameter int GW = GAP_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // settings
    input wire logic i_en,
    input wire logic [GW-1:0] i_sym_gap,
    input wire logic [GW-1:0] i_tok_gap,
    // symbol handshake
    input wire logic i_sym_valid,
    input wire logic i_sym_last,
    output logic o_sym_ready
);
    logic [GW:0] cnt_q;
    logic [GW:0] load;
    logic take;

    assign o_sym_ready = i_en && (cnt_q == '0);
    assign take = i_ce && i_sym_valid && o_sym_ready;
    // (R9) (R10) gap plus one idle
    assign load = i_sym_last ? ({1'b0, i_tok_gap} + 1'b1)
                             : ({1'b0, i_sym_gap} + 1'b1);

    // idle counter, gap is a minimum so a slow source is fine
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= '0;
        end else if (take) begin
            cnt_q <= load;
        end else if (i_ce && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    a_pace_load: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R9)
        take |=> cnt_q == $past(load))
        else $error("pacing counter not loaded with gap plus one");
    a_pace_hold: assert property (@(posedge i_clk) // (R10)
        disable iff (!i_nrst) take |=> !o_sym_ready)
        else $error("symbol ready during idle gap");
    a_pace_idle: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R9)
        (take && !i_sym_last && i_sym_gap == '0)
            |=> !o_sym_ready ##1 (o_sym_ready || !$past(i_ce) || !i_en))
        else $error("zero gap must give exactly one idle clock");
endmodule

// Contract
// (R1) enable bit turns link on and off
// (R2) enable bit gives pins to the link
// (R3) width bit: clear two wire, set five
// (R4) receive error on overflow or bad token
// (R5) status shows credit granted to remote
// (R6) status shows credit held for sending
// (R7) greeting clears credit, sends greeting token
// (R8) restart resets receiver to token start
// (R9) symbol gap at least field plus one
// (R10) token gap at least field plus one
// (R11) eight control registers from base index
// (R12) fixed forward sends all to endpoint
// (R13) one bit selects destination processor
// (R14) five bit field selects target endpoint
// (R15) forward registers ordered C,D,A,B,G,H,E,F
// (R16) command bits pulse, read zero
module elc_link_cfg
    import elc_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // register port
    input wire logic [AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // link datapath events
    input wire logic [NLINK-1:0] i_rx_overflow,
    input wire logic [NLINK-1:0] i_rx_illegal,
    input wire logic [NLINK-1:0] i_credit_issued,
    input wire logic [NLINK-1:0] i_credit_received,
    // transmit symbol handshake
    input wire logic [NLINK-1:0] i_sym_valid,
    input wire logic [NLINK-1:0] i_sym_last,
    output logic [NLINK-1:0] o_sym_ready,
    // link control outputs
    output logic [NLINK-1:0] o_link_en,
    output logic [NLINK-1:0] o_pin_own,
    output logic [NLINK-1:0] o_wide_signalling_select,
    output logic [NLINK-1:0] o_send_greeting,
    output logic [NLINK-1:0] o_receiver_restart,
    // fixed forwarding per link, indexed by link letter A=0
    output elc_fwd_s [NLINK-1:0] o_fwd,
    // interrupt
    output logic o_irq
);
    elc_ctl_s [NLINK-1:0] ctl_q;
    elc_fwd_s [NLINK-1:0] fwd_q;
    logic [NLINK-1:0] rxerr_q;
    logic [NLINK-1:0] rxcr_q;
    logic [NLINK-1:0] txcr_q;
    logic [NLINK-1:0] greet_q;
    logic [NLINK-1:0] rst_q;
    logic [2*NLINK-1:0] stat_q;
    logic [2*NLINK-1:0] mask_q;
    logic [31:0] rdata_q;
    logic [NLINK-1:0] ctl_wr;
    logic [NLINK-1:0] fwd_wr;
    logic [NLINK-1:0] err_ev;
    logic [NLINK-1:0] cr_ev;
    logic [31:0] rd_d;
    logic wr;
    logic rd;

    assign wr = i_ce && i_wr;
    assign rd = i_ce && i_rd;
    assign err_ev = i_rx_overflow | i_rx_illegal;
    assign cr_ev = i_credit_received & ~txcr_q;

    // (R11) one control register per link
    always_comb begin
        for (int n = 0; n < NLINK; n++) begin
            ctl_wr[n] = wr && (i_addr == CTL_BASE + AW'(n));
            fwd_wr[n] = wr && (i_addr == FWD_BASE + AW'(n));
        end
    end

    // configuration registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctl_q <= '0;
        end else begin
            for (int n = 0; n < NLINK; n++) begin
                if (ctl_wr[n]) begin
                    // (R1) (R3) enable and width from write
                    ctl_q[n].en <= i_wdata[B_EN];
                    ctl_q[n].wide <= i_wdata[B_WIDE];
                    ctl_q[n].sym_gap <= i_wdata[SYM_LSB +: GAP_W];
                    ctl_q[n].tok_gap <= i_wdata[TOK_LSB +: GAP_W];
                end
            end
        end
    end

    // fixed forwarding registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fwd_q <= '0;
        end else begin
            for (int n = 0; n < NLINK; n++) begin
                if (fwd_wr[n]) begin
                    // (R12) (R13) (R14) forward fields
                    fwd_q[n].en <= i_wdata[F_EN];
                    fwd_q[n].proc <= i_wdata[F_PROC];
                    fwd_q[n].endpoint <= i_wdata[F_EP_LSB +: EP_W];
                end
            end
        end
    end

    // command pulses, one cycle after the write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            greet_q <= '0;
            rst_q <= '0;
        end else if (i_ce) begin
            for (int n = 0; n < NLINK; n++) begin
                // (R16) zero write does nothing
                greet_q[n] <= ctl_wr[n] && i_wdata[B_GREET];
                rst_q[n] <= ctl_wr[n] && i_wdata[B_RXRST];
            end
        end
    end

    // link status; a new event beats a same-cycle clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rxerr_q <= '0;
            rxcr_q <= '0;
            txcr_q <= '0;
        end else if (i_ce) begin
            // (R4) error sticky until receiver restart
            rxerr_q <= err_ev | (rxerr_q & ~rst_q);
            // (R5) granted credit dropped by restart
            rxcr_q <= i_credit_issued | (rxcr_q & ~rst_q);
            // (R6) (R7) held credit dropped by greeting
            txcr_q <= i_credit_received | (txcr_q & ~greet_q);
        end
    end

    // interrupt status, write one to clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stat_q <= '0;
            mask_q <= '0;
        end else if (i_ce) begin
            if (wr && i_addr == IRQ_MASK) begin
                mask_q <= i_wdata[2*NLINK-1:0];
            end
            if (wr && i_addr == IRQ_STAT) begin
                stat_q <= {cr_ev, err_ev} |
                          (stat_q & ~i_wdata[2*NLINK-1:0]);
            end else begin
                stat_q <= {cr_ev, err_ev} | stat_q;
            end
        end
    end

    // read mux; command and reserved bits read zero
    always_comb begin
        rd_d = RST_WORD;
        for (int n = 0; n < NLINK; n++) begin
            if (i_addr == CTL_BASE + AW'(n)) begin
                rd_d[B_EN] = ctl_q[n].en;
                rd_d[B_WIDE] = ctl_q[n].wide;
                rd_d[B_RXERR] = rxerr_q[n];
                rd_d[B_RXCR] = rxcr_q[n];
                rd_d[B_TXCR] = txcr_q[n];
                rd_d[SYM_LSB +: GAP_W] = ctl_q[n].sym_gap;
                rd_d[TOK_LSB +: GAP_W] = ctl_q[n].tok_gap;
            end
            if (i_addr == FWD_BASE + AW'(n)) begin
                rd_d[F_EN] = fwd_q[n].en;
                rd_d[F_PROC] = fwd_q[n].proc;
                rd_d[F_EP_LSB +: EP_W] = fwd_q[n].endpoint;
            end
        end
        if (i_addr == IRQ_STAT) begin
            rd_d[2*NLINK-1:0] = stat_q;
        end
        if (i_addr == IRQ_MASK) begin
            rd_d[2*NLINK-1:0] = mask_q;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q <= '0;
        end else if (i_ce) begin
            rdata_q <= rd ? rd_d : RST_WORD;
        end
    end

    // per-link pacing and outputs
    for (genvar g = 0; g < NLINK; g++) begin : g_link
        // (R9) (R10) symbol and token gaps
        elc_pace #(.GW(GAP_W)) u_pace (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_ce(i_ce),
            .i_en(ctl_q[g].en),
            .i_sym_gap(ctl_q[g].sym_gap),
            .i_tok_gap(ctl_q[g].tok_gap),
            .i_sym_valid(i_sym_valid[g]),
            .i_sym_last(i_sym_last[g]),
            .o_sym_ready(o_sym_ready[g])
        );
        // (R15) letter order of forward registers
        assign o_fwd[g] = fwd_q[3'(g) ^ FWD_SWAP];
    end

    // (R1) (R2) enable drives link and pin mux
    always_comb begin
        for (int n = 0; n < NLINK; n++) begin
            o_link_en[n] = ctl_q[n].en;
        end
    end
    assign o_pin_own = o_link_en;
    // (R3) wide select
    always_comb begin
        for (int n = 0; n < NLINK; n++) begin
            o_wide_signalling_select[n] = ctl_q[n].wide;
        end
    end
    // (R7) (R8) command pulses out
    assign o_send_greeting = greet_q;
    assign o_receiver_restart = rst_q;
    assign o_rdata = rdata_q;
    assign o_irq = |(stat_q & mask_q);

    a_en_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R1)
        ctl_wr[0] |=> o_link_en[0] == $past(i_wdata[B_EN]))
        else $error("link enable does not follow write");
    a_pin_mux: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R2)
        o_pin_own == o_link_en)
        else $error("pin ownership differs from enable");
    a_wide_write: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R3)
        ctl_wr[3] |=> o_wide_signalling_select[3] == $past(i_wdata[B_WIDE]))
        else $error("width select does not follow write");
    a_err_set: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R4)
        (i_ce && err_ev[0]) |=> rxerr_q[0] && stat_q[I_ERR_LSB])
        else $error("receive error not flagged");
    a_rxcr_clr: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R5)
        (i_ce && rst_q[1] && !i_credit_issued[1]) |=> !rxcr_q[1])
        else $error("granted credit survives restart");
    a_txcr_set: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R6)
        (i_ce && i_credit_received[2]) |=> txcr_q[2])
        else $error("held credit not shown");
    a_greet_seq: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R7)
        (ctl_wr[0] && i_wdata[B_GREET] && i_ce) |=> o_send_greeting[0]
            ##1 (!$past(i_ce) || ((!o_send_greeting[0] || $past(ctl_wr[0]))
            && (txcr_q[0] == $past(i_credit_received[0])))))
        else $error("greeting pulse or credit clear wrong");
    a_restart_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R8)
        (ctl_wr[5] && i_wdata[B_RXRST]) |=> o_receiver_restart[5])
        else $error("receiver restart pulse missing");
    a_ctl_read: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R11)
        (rd && i_addr == CTL_BASE + AW'(7)) |=>
            o_rdata[TOK_LSB +: GAP_W] == $past(ctl_q[7].tok_gap))
        else $error("control register seven misread");
    a_fwd_map: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R15)
        o_fwd[0] == fwd_q[2] && o_fwd[2] == fwd_q[0] && o_fwd[4] == fwd_q[6])
        else $error("forward letter order wrong");
    a_fwd_field: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R14)
        fwd_wr[1] |=> o_fwd[3].endpoint == $past(i_wdata[EP_W-1:0])
            && o_fwd[3].en == $past(i_wdata[F_EN])
            && o_fwd[3].proc == $past(i_wdata[F_PROC]))
        else $error("forward fields not stored");
    a_cmd_zero: assert property (@(posedge i_clk) disable iff (!i_nrst) // (R16)
        $past(rd) && $past(i_ce) |-> !o_rdata[B_GREET] && !o_rdata[B_RXRST])
        else $error("command bit reads nonzero");
    a_irq_level: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_irq == |(stat_q & mask_q))
        else $error("interrupt level wrong");

    // flag, pulse, forward and read port checks
    a_en_hold: assert property (@(posedge i_clk) // (R1)
        disable iff (!i_nrst) !ctl_wr[2] |=> $stable(o_link_en[2]))
        else $error("link enable changed without a write");
    a_ready_off: assert property (@(posedge i_clk) // (R1)
        disable iff (!i_nrst) !o_link_en[3] |-> !o_sym_ready[3])
        else $error("disabled link offers symbol ready");
    a_wide_hold: assert property (@(posedge i_clk) // (R3)
        disable iff (!i_nrst)
        !ctl_wr[6] |=> $stable(o_wide_signalling_select[6]))
        else $error("width select changed without a write");
    a_err_hold: assert property (@(posedge i_clk) // (R4)
        disable iff (!i_nrst) (i_ce && rxerr_q[3] && !rst_q[3]) |=> rxerr_q[3])
        else $error("receive error lost without restart");
    a_stat_clear: assert property (@(posedge i_clk) // (R4)
        disable iff (!i_nrst)
        (wr && i_addr == IRQ_STAT && i_wdata[I_ERR_LSB + 1]
            && !err_ev[1]) |=> !stat_q[I_ERR_LSB + 1])
        else $error("error status not cleared by write one");
    a_rxcr_set: assert property (@(posedge i_clk) // (R5)
        disable iff (!i_nrst) (i_ce && i_credit_issued[2]) |=> rxcr_q[2])
        else $error("granted credit not shown");
    a_txcr_clr: assert property (@(posedge i_clk) // (R7)
        disable iff (!i_nrst)
        (i_ce && greet_q[5] && !i_credit_received[5]) |=> !txcr_q[5])
        else $error("held credit survives greeting");
    a_err_clr: assert property (@(posedge i_clk) // (R8)
        disable iff (!i_nrst) (i_ce && rst_q[2] && !err_ev[2]) |=> !rxerr_q[2])
        else $error("receive error survives restart");
    a_fwd_en: assert property (@(posedge i_clk) // (R12)
        disable iff (!i_nrst)
        fwd_wr[6] |=> o_fwd[4].en == $past(i_wdata[F_EN]))
        else $error("forward enable not stored");
    a_fwd_proc: assert property (@(posedge i_clk) // (R13)
        disable iff (!i_nrst)
        fwd_wr[5] |=> o_fwd[7].proc == $past(i_wdata[F_PROC]))
        else $error("forward processor not stored");
    a_greet_zero: assert property (@(posedge i_clk) // (R16)
        disable iff (!i_nrst)
        (ctl_wr[4] && !i_wdata[B_GREET]) |=> !o_send_greeting[4])
        else $error("greeting sent on a zero write");
    a_restart_once: assert property (@(posedge i_clk) // (R16)
        disable iff (!i_nrst)
        o_receiver_restart[5] |->
            $past(ctl_wr[5] && i_wdata[B_RXRST]) || !$past(i_ce))
        else $error("restart pulse without a command write");
    a_rd_idle: assert property (@(posedge i_clk)
        disable iff (!i_nrst)
        ($past(i_ce) && !$past(rd)) |-> o_rdata == RST_WORD)
        else $error("read data outside the read cycle");
endmodule

`default_nettype wire

// file: testbench/elc_remote_model.sv
// remote link endpoint model facing the link control block
// assumes bench commands are one-cycle pulses on i_clk
`timescale 1ns/1ps
`default_nettype none
module elc_remote_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // greeting seen from the device, bench commands
    input wire logic [7:0] i_greeting,
    input wire logic [7:0] i_flood,
    input wire logic [7:0] i_bad_token,
    input wire logic [7:0] i_want_credit,
    // events into the device
    output logic [7:0] o_rx_overflow,
    output logic [7:0] o_rx_illegal,
    output logic [7:0] o_credit_issued,
    output logic [7:0] o_credit_received
);
    logic [5:0][7:0] greet_q;
    // greeting answered with credit
    // slow answer, so the cleared credit is visible first
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            greet_q <= '0;
            o_credit_received <= 8'h00;
        end else begin
            greet_q <= {greet_q[4:0], i_greeting};
            o_credit_received <= greet_q[5];
        end
    end
    // overflow, bad token and credit grant
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_overflow <= 8'h00;
            o_rx_illegal <= 8'h00;
            o_credit_issued <= 8'h00;
        end else begin
            o_rx_overflow <= i_flood;
            o_rx_illegal <= i_bad_token;
            o_credit_issued <= i_want_credit;
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// self-checking bench for the link control block
// assumes one 20 MHz clock and the remote model beside the block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import elc_pkg::*;
    localparam logic [2:0] LETTER [8] = '{3'h2, 3'h3, 3'h0, 3'h1,
                                         3'h6, 3'h7, 3'h4, 3'h5};
    logic i_clk, i_nrst, i_ce, i_wr, i_rd, irq;
    logic [AW-1:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rv, d;
    logic [NLINK-1:0] s_valid, s_last, s_ready, link_en, pin_own, wide;
    logic [NLINK-1:0] greet, restart, ovf, ill, c_iss, c_rcv;
    logic [7:0] flood, bad, want;
    elc_fwd_s [NLINK-1:0] fwd;
    int n_mismatch, comparisons, seed, n;
    int cycles = 0;

    elc_link_cfg elc_link_cfg_inst (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_overflow(ovf),
        .i_rx_illegal(ill), .i_credit_issued(c_iss),
        .i_credit_received(c_rcv), .i_sym_valid(s_valid),
        .i_sym_last(s_last), .o_sym_ready(s_ready), .o_link_en(link_en),
        .o_pin_own(pin_own), .o_wide_signalling_select(wide),
        .o_send_greeting(greet), .o_receiver_restart(restart),
        .o_fwd(fwd), .o_irq(irq));
    elc_remote_model elc_remote_model_inst (.i_clk(i_clk),
        .i_nrst(i_nrst), .i_greeting(greet), .i_flood(flood),
        .i_bad_token(bad), .i_want_credit(want), .o_rx_overflow(ovf),
        .o_rx_illegal(ill), .o_credit_issued(c_iss),
        .o_credit_received(c_rcv));

    // free-running clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // hang guard, well above the few hundred cycles needed
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    function automatic logic [31:0] exp_ctl(input logic [31:0] v);
        return v & 32'hC03F_FFFF; // command and reserved bits read zero, status bits expected clear here
    endfunction
    function automatic logic [31:0] exp_fwd(input logic [31:0] v);
        return v & 32'h8000_011F;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // idle cycles after one take on link 3
    task automatic pace(input logic lst, input logic [31:0] gap);
        int k;
        k = 0;
        @(posedge i_clk);
        s_last[3] <= lst;
        #1;
        while (s_ready[3] !== 1'b1 && k < 5000) begin
            @(posedge i_clk);
            #1 k++;
        end
        @(posedge i_clk);
        #1 k = 0;
        while (s_ready[3] !== 1'b1 && k < 5000) begin
            k++;
            @(posedge i_clk);
            #1;
        end
        chk(32'(k), gap + 32'h1);
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        seed = 36;
        {i_nrst, i_wr, i_rd, s_valid, s_last, flood, bad, want} = '0;
        i_ce = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        // reset values, random round trips, outputs per link
        for (n = 0; n < NLINK; n++) begin
            rd(CTL_BASE + 8'(n), rv);
            chk(rv, 32'h0);
            rd(FWD_BASE + 8'(n), rv);
            chk(rv, 32'h0);
            d = $random(seed) & 32'hFE7F_FFFF;
            wr(CTL_BASE + 8'(n), d);
            rd(CTL_BASE + 8'(n), rv);
            chk(rv, exp_ctl(d));
            chk({31'h0, link_en[n]}, {31'h0, d[31]});
            chk({31'h0, pin_own[n]}, {31'h0, d[31]});
            chk({31'h0, wide[n]}, {31'h0, d[30]});
            d = $random(seed);
            wr(FWD_BASE + 8'(n), d);
            rd(FWD_BASE + 8'(n), rv);
            chk(rv, exp_fwd(d));
            chk({25'h0, fwd[LETTER[n]]}, {25'h0, d[31], d[8], d[4:0]});
        end
        // unmapped places ignore writes and read zero
        wr(8'h90, 32'hFFFF_FFFF);
        rd(8'h90, rv);
        chk(rv, 32'h0);
        rd(8'h88, rv);
        chk(rv, 32'h0);
        // greeting on link 5, answered later with credit
        wr(CTL_BASE + 8'h05, 32'h0100_0000);
        chk({24'h0, greet}, 32'h20);
        @(posedge i_clk);
        #1 chk({24'h0, greet}, 32'h0);
        repeat (10) @(posedge i_clk);
        wr(CTL_BASE + 8'h05, 32'h0);
        rd(CTL_BASE + 8'h05, rv);
        chk(rv, 32'h0200_0000);
        rd(IRQ_STAT, rv);
        chk(rv, 32'h0000_2000);
        wr(IRQ_STAT, 32'h0000_2000);
        wr(CTL_BASE + 8'h05, 32'h0100_0000);
        rd(CTL_BASE + 8'h05, rv);
        chk(rv, 32'h0);
        // strobes while the clock enable is low leave state frozen
        i_ce <= 1'b0;
        wr(CTL_BASE + 8'h05, 32'h8000_0000);
        i_ce <= 1'b1;
        rd(CTL_BASE + 8'h05, rv);
        chk(rv, 32'h0);
        chk({31'h0, link_en[5]}, 32'h0);
        // errors on links 2 and 6, credit grant on link 2
        repeat (10) @(posedge i_clk);
        wr(IRQ_STAT, 32'h0000_FFFF);
        wr(IRQ_MASK, 32'h0);
        @(posedge i_clk);
        bad[2] <= 1'b1;
        want[2] <= 1'b1;
        flood[6] <= 1'b1;
        @(posedge i_clk);
        {bad, want, flood} <= '0;
        repeat (3) @(posedge i_clk);
        #1 chk({31'h0, irq}, 32'h0);
        rd(CTL_BASE + 8'h02, rv);
        chk(rv & 32'h0E00_0000, 32'h0C00_0000);
        rd(CTL_BASE + 8'h06, rv);
        chk(rv & 32'h0800_0000, 32'h0800_0000);
        wr(IRQ_MASK, 32'h0000_0004);
        @(posedge i_clk);
        #1 chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT, 32'h0000_0004);
        @(posedge i_clk);
        #1 chk({31'h0, irq}, 32'h0);
        rd(IRQ_STAT, rv);
        chk(rv, 32'h0000_0040);
        wr(CTL_BASE + 8'h02, 32'h0080_0000);
        chk({24'h0, restart}, 32'h04);
        @(posedge i_clk);
        rd(CTL_BASE + 8'h02, rv);
        chk(rv, 32'h0);
        // symbol and token gaps on link 3, zero gap boundary too
        wr(CTL_BASE + 8'h03, 32'h8000_1004);
        s_valid[3] <= 1'b1;
        pace(1'b0, 32'h2);
        pace(1'b1, 32'h4);
        wr(CTL_BASE + 8'h03, 32'h8000_0000);
        pace(1'b0, 32'h0);
        wr(CTL_BASE + 8'h03, 32'h0);
        @(posedge i_clk);
        #1 chk({31'h0, s_ready[3]}, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
